/* File: common/wspci_pkg.sv */
// constants and types of the wrapper serial port chip interconnect
package wspci_pkg;

	////////////////////////////////////////////////////////////////
	// instructions
	localparam int IW = 3;
	localparam logic [2:0] INSTR_BYPASS = 3'h0;
	localparam logic [2:0] INSTR_EXTEST = 3'h1;
	localparam logic [2:0] INSTR_SUBLINK = 3'h2;
	localparam logic [2:0] IR_CAPTURE = 3'h1;

	////////////////////////////////////////////////////////////////
	// interconnect arrangements
	typedef enum logic [3:0] {
		MODE_SERIAL = 4'h1,
		MODE_PARALLEL = 4'h2,
		MODE_NEST_FIXED = 4'h4,
		MODE_NEST_MUX = 4'h8
	} wspci_mode_t;
	localparam logic [3:0] MODE_RST = 4'h1;

	////////////////////////////////////////////////////////////////
	// register map
	localparam int AW = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int STS_RUN_BIT = 16;
	localparam logic [31:0] RDATA_RST = 32'h0;

	////////////////////////////////////////////////////////////////
	// synchroniser
	localparam int SYNC_STAGES = 3;

endpackage

/* File: tb/wspci_ctrl_model.sv */
// chip-level test controller driving the shared wrapper controls
`timescale 1ns/1ps
module wspci_ctrl_model #(
	parameter int NCORE = 4
) (
	// shared controls
	output logic wrapper_test_clock,
	output logic auxiliary_clock,
	output logic wrapper_reset_n,
	output logic instr_reg_select,
	output logic shift_ctrl,
	output logic capture_ctrl,
	output logic update_ctrl,
	output logic transfer_ctrl,
	// serial lanes
	output logic [NCORE-1:0] wrapper_serial_in,
	input wire logic [NCORE-1:0] wrapper_serial_out
);
	initial begin
		{wrapper_test_clock, auxiliary_clock, instr_reg_select, shift_ctrl} = 4'h0;
		{capture_ctrl, update_ctrl, transfer_ctrl} = 3'h0;
		wrapper_reset_n = 1'b0;
		wrapper_serial_in = '0;
	end

	// one control set for all cores, moved clear of both edges
	task automatic cyc(input logic [4:0] c, input logic [NCORE-1:0] si, output logic [NCORE-1:0] so);
		{transfer_ctrl, update_ctrl, capture_ctrl, shift_ctrl, instr_reg_select} = c;
		wrapper_serial_in = si;
		#2 wrapper_test_clock = 1'b1;
		#3 wrapper_test_clock = 1'b0;
		#1 so = wrapper_serial_out;
	endtask

	// clock kept running in reset, then idle edges for the mode sync
	task automatic wreset();
		logic [NCORE-1:0] so;
		wrapper_reset_n = 1'b0;
		repeat (2) cyc(5'h0, '1, so);
		wrapper_reset_n = 1'b1;
		repeat (6) cyc(5'h0, '0, so);
	endtask
endmodule

/* File: tb/wspci_sva.sv */
// bus and link checks of the interconnect
`timescale 1ns/1ps
module wspci_sva #(
	parameter int NCORE = 4,
	parameter int BLEN = 4
) (
	// register bus
	input wire logic clk,
	input wire logic resetn,
	input wire logic [wspci_pkg::AW-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// link
	input wire logic wrapper_test_clock,
	input wire logic wrapper_reset_n,
	input wire logic [NCORE-1:0] wrapper_serial_out,
	input wire logic [NCORE*BLEN-1:0] core_func_out
);
	logic [NCORE-1:0] rise_q;

	// out value seen at the rising edge must still stand at the next falling edge
	always_ff @(posedge wrapper_test_clock or negedge wrapper_reset_n) begin
		if (!wrapper_reset_n)
			rise_q <= '0;
		else
			rise_q <= wrapper_serial_out;
	end

	////////////////////////////////////////////////////////////////
	a_wait_answer: assert property (@(posedge clk) disable iff (!resetn)
		(read || write) && waitrequest |=> !waitrequest) else $error("access not answered");
	a_wait_single: assert property (@(posedge clk) disable iff (!resetn)
		!waitrequest |=> waitrequest) else $error("waitrequest low too long");
	a_wait_idle: assert property (@(posedge clk) disable iff (!resetn)
		!(read || write) |=> waitrequest) else $error("answer without access");
	a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
		waitrequest ##1 waitrequest |-> $stable(readdata)) else $error("readdata moved");
	a_status_run: assert property (@(posedge clk) disable iff (!resetn)
		read && !waitrequest && address == wspci_pkg::REG_STATUS |-> readdata[wspci_pkg::STS_RUN_BIT])
		else $error("status run bit low");
	a_unmapped_zero: assert property (@(posedge clk) disable iff (!resetn)
		read && !waitrequest && address != wspci_pkg::REG_CTRL && address != wspci_pkg::REG_STATUS
		|-> readdata == 32'h0) else $error("unmapped read not zero");
	a_reset_quiet: assert property (@(posedge wrapper_test_clock)
		!wrapper_reset_n |-> wrapper_serial_out == '0 && core_func_out == '0) else $error("outputs live in reset");
	a_out_on_fall: assert property (@(negedge wrapper_test_clock) disable iff (!wrapper_reset_n)
		wrapper_serial_out == rise_q) else $error("serial out moved on rising edge");
endmodule

bind wspci_top wspci_sva #(.NCORE(NCORE), .BLEN(BLEN)) u_sva (.clk, .resetn, .address, .read, .write,
	.readdata, .waitrequest, .wrapper_test_clock, .wrapper_reset_n, .wrapper_serial_out, .core_func_out);

/* File: tb/wspci_top_tb.sv */
// self-checking bench of the wrapper serial port interconnect
`timescale 1ns/1ps
module wspci_top_tb;
	localparam int NC = 4;
	localparam int BL = 4;
	localparam logic [3:0] MD [3] = '{4'h1, 4'h4, 4'h8};
	localparam int LN [3] = '{3, 1, 1};
	localparam int OF [3] = '{3, 3, 1};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, q;
	logic waitrequest, wrapper_test_clock, auxiliary_clock, wrapper_reset_n, instr_reg_select;
	logic shift_ctrl, capture_ctrl, update_ctrl, transfer_ctrl;
	logic [NC-1:0] wrapper_serial_in, wrapper_serial_out, so;
	logic [NC*BL-1:0] core_func_in = 16'h0;
	logic [NC*BL-1:0] core_func_out;
	logic [15:0] r, rc;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;

	wspci_top #(.NCORE(NC), .BLEN(BL)) DUT (.clk, .resetn, .address, .read, .write, .writedata, .readdata,
		.waitrequest, .wrapper_test_clock, .auxiliary_clock, .wrapper_reset_n, .instr_reg_select, .shift_ctrl,
		.capture_ctrl, .update_ctrl, .transfer_ctrl, .wrapper_serial_in, .wrapper_serial_out, .core_func_in,
		.core_func_out);
	wspci_ctrl_model #(.NCORE(NC)) ctl (.wrapper_test_clock, .auxiliary_clock, .wrapper_reset_n,
		.instr_reg_select, .shift_ctrl, .capture_ctrl, .update_ctrl, .transfer_ctrl, .wrapper_serial_in,
		.wrapper_serial_out);

	initial forever #50 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// status crosses from the link side, so give it time to settle
	task automatic status(input logic [31:0] e);
		repeat (8) @(posedge clk);
		bus(1'b0, wspci_pkg::REG_STATUS, 32'h0);
		chk("status", e, q);
	endtask

	task automatic mode(input logic [3:0] m);
		bus(1'b1, wspci_pkg::REG_CTRL, {28'h0, m});
		repeat (6) ctl.cyc(5'h0, '0, so);
	endtask

	// odd lanes carry the inverted stream
	task automatic frame(input logic [4:0] c, input int n, input logic [15:0] d, input int l, output logic [15:0] o);
		for (int i = 0; i < n; i++) begin
			ctl.cyc(c, {NC{d[i]}} ^ 4'hA, so);
			o[i] = so[l];
		end
	endtask

	task automatic path(input string nm, input int n, input int l, input int off, input logic inv);
		logic [15:0] m;
		m = 16'hFFFF >> (16 - n + off);
		frame(5'h2, n, 16'hB4E9, l, r);
		chk(nm, {16'h0, (16'hB4E9 ^ {16{inv}}) & m}, {16'h0, (r >> off) & m});
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		ctl.wreset();
		bus(1'b0, wspci_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h1, q);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, wspci_pkg::REG_CTRL, 32'h3);
		bus(1'b0, wspci_pkg::REG_CTRL, 32'h0);
		chk("ctrl refused", 32'h1, q);
		status(32'h1000F);
		$display("register test done");
		for (int k = 0; k < 3; k++) begin
			mode(MD[k]);
			path("bypass chain", 8, LN[k], OF[k], 1'b0);
		end
		mode(4'h2);
		for (int k = 0; k < NC; k++) path("parallel lane", 8, k, 0, k[0]);
		$display("arrangement test done");
		mode(4'h1);
		frame(5'h1, 1, 16'h0, 3, rc);
		frame(5'h5, 1, 16'h0, 3, rc);
		frame(5'h3, 12, 16'h200, 3, r);
		chk("instruction chain", 32'h249, {19'h0, r[11:0], rc[0]});
		frame(5'h9, 1, 16'h0, 3, rc);
		frame(5'h0, 1, 16'h0, 3, rc);
		status(32'h1000E);
		path("extest chain", 12, 3, 6, 1'b0);
		frame(5'h8, 1, 16'h0, 3, rc);
		chk("boundary apply", 32'h4, {16'h0, core_func_out});
		frame(5'h10, 1, 16'h0, 3, rc);
		frame(5'h2, 6, 16'h0, 3, r);
		chk("boundary transfer", 32'h4, {28'h0, r[5:2]});
		$display("instruction test done");
		ctl.wreset();
		status(32'h1000F);
		path("bypass after reset", 8, 3, 3, 1'b0);
		$display("reset test done");
		give_verdict();
	end
endmodule

/* File: verilog/wspci_avmm.sv */
// register slave on the avalon bus: arrangement control and link status
`timescale 1ns/1ps
module wspci_avmm #(
	parameter int SW = 5
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [wspci_pkg::AW-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// block side
	input wire logic [SW-1:0] status,
	output logic [3:0] mode
);
	typedef struct packed {
		logic [3:0] mode;
		logic wait_req;
		logic [31:0] rdata;
	} wspci_avmm_t;

	wspci_avmm_t st_r;
	wspci_avmm_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (st_r.wait_req) begin
			// accept: read data is prepared here and stands at the completing edge
			if (read || write) begin
				st_nxt.wait_req = 1'b0;
				st_nxt.rdata = 32'h0;
				if (read && address == wspci_pkg::REG_CTRL) begin
					st_nxt.rdata[3:0] = st_r.mode;
				end
				if (read && address == wspci_pkg::REG_STATUS) begin
					st_nxt.rdata[SW-2:0] = status[SW-2:0];
					st_nxt.rdata[wspci_pkg::STS_RUN_BIT] = status[SW-1];
				end
			end
		end else begin
			st_nxt.wait_req = 1'b1;
			// non one-hot arrangements are ignored so the link sees no illegal code except the 0 its synchroniser holds after wrapper reset
			if (write && address == wspci_pkg::REG_CTRL && $onehot(writedata[3:0])) begin
				st_nxt.mode = writedata[3:0];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r.mode <= wspci_pkg::MODE_RST;
			st_r.wait_req <= 1'b1;
			st_r.rdata <= wspci_pkg::RDATA_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign readdata = st_r.rdata;
	assign waitrequest = st_r.wait_req;
	assign mode = st_r.mode;
endmodule

/* File: verilog/wspci_sync.sv */
// three-stage level synchroniser with agreement check
`timescale 1ns/1ps
module wspci_sync #(
	parameter int W = 1
) (
	// clock and reset of the receiving side
	input wire logic clk,
	input wire logic rst_n,
	// level from the other domain
	input wire logic [W-1:0] d,
	// accepted value
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} wspci_sync_t;

	wspci_sync_t st_r;
	wspci_sync_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// a change counts once stages two and three agree
		if (st_r.s2 == st_r.s3) begin
			st_nxt.q = st_r.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.q;
endmodule

/* File: verilog/wspci_top.sv */
// chip-level interconnect of core wrapper serial ports
`timescale 1ns/1ps
module wspci_top #(
	parameter int NCORE = 4,
	parameter int BLEN = 4,
	parameter int PARENT = 1,
	parameter bit USE_AUX = 1'b0
) (
	// system clock and reset
	input wire logic clk,
	input wire logic resetn,
	// avalon-mm register slave
	input wire logic [wspci_pkg::AW-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// shared wrapper controls
	input wire logic wrapper_test_clock,
	input wire logic auxiliary_clock,
	input wire logic wrapper_reset_n,
	input wire logic instr_reg_select,
	input wire logic shift_ctrl,
	input wire logic capture_ctrl,
	input wire logic update_ctrl,
	input wire logic transfer_ctrl,
	// serial data, one lane per core
	input wire logic [NCORE-1:0] wrapper_serial_in,
	output logic [NCORE-1:0] wrapper_serial_out,
	// core functional terminals seen by the boundary registers
	input wire logic [NCORE*BLEN-1:0] core_func_in,
	output logic [NCORE*BLEN-1:0] core_func_out
);
	localparam int IW = wspci_pkg::IW;

	////////////////////////////////////////////////////////////////
	// state: rising-edge, falling-edge and auxiliary parts of the link

	typedef struct packed {
		logic [NCORE-1:0][IW-1:0] ir_sh;
		logic [NCORE-1:0] byp;
		logic [NCORE-1:0][BLEN-1:0] bnd;
	} wspci_rise_t;

	typedef struct packed {
		logic [NCORE-1:0][IW-1:0] ir;
		logic [NCORE-1:0] byp_eff;
		logic [NCORE-1:0] own_so;
		logic [NCORE-1:0] fin_so;
		logic [NCORE-1:0][BLEN-1:0] apl;
		logic [NCORE-1:0] tgl;
	} wspci_fall_t;

	typedef struct packed {
		logic [NCORE-1:0][BLEN-1:0] apl;
		logic [NCORE-1:0] seen;
	} wspci_aux_t;

	wspci_rise_t rs_r;
	wspci_rise_t rs_nxt;
	wspci_fall_t fs_r;
	wspci_fall_t fs_nxt;
	wspci_aux_t ax_r;
	wspci_aux_t ax_nxt;

	logic [3:0] mode_cfg;
	logic [3:0] mode_q;
	logic [NCORE-1:0] tgl_q;
	logic [NCORE:0] sts_src;
	logic [NCORE:0] sts_q;
	logic [NCORE-1:0] si;
	logic [NCORE-1:0] tail;
	logic nested;
	logic ret;

	////////////////////////////////////////////////////////////////
	// register slave and crossings

	wspci_avmm #(
		.SW(NCORE + 1)
	) u_avmm (
		.clk(clk),
		.resetn(resetn),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.status(sts_q),
		.mode(mode_cfg)
	);

	// arrangement word is quasi-static; it is taken only once all bits agree
	wspci_sync #(
		.W(4)
	) u_mode_sync (
		.clk(wrapper_test_clock),
		.rst_n(wrapper_reset_n),
		.d(mode_cfg),
		.q(mode_q)
	);

	// per-core bypass levels and a run level tied high back to the bus side
	assign sts_src = {1'b1, fs_r.byp_eff};

	wspci_sync #(
		.W(NCORE + 1)
	) u_sts_sync (
		.clk(clk),
		.rst_n(resetn),
		.d(sts_src),
		.q(sts_q)
	);

	// boundary update events handed to the auxiliary clock by toggle
	wspci_sync #(
		.W(NCORE)
	) u_tgl_sync (
		.clk(auxiliary_clock),
		.rst_n(wrapper_reset_n),
		.d(fs_r.tgl),
		.q(tgl_q)
	);

	////////////////////////////////////////////////////////////////
	// serial routing

	assign nested = (mode_q == wspci_pkg::MODE_NEST_FIXED) || (mode_q == wspci_pkg::MODE_NEST_MUX);
	// last subcore output returns to the parent
	assign ret = tail[NCORE-1];

	// nested order: core 0, the parent, then subcores from PARENT+1 up to the last core,
	// whose tail comes back into the parent; nothing checks PARENT against NCORE,
	// so a parent placed at the last core leaves no subcore to chain

	always_comb begin
		for (int k = 0; k < NCORE; k++) begin
			// selected register tail, as picked by the rising edge
			if (instr_reg_select) begin
				tail[k] = rs_r.ir_sh[k][0];
			end else if (fs_r.ir[k] == wspci_pkg::INSTR_EXTEST) begin
				tail[k] = rs_r.bnd[k][0];
			end else begin
				tail[k] = rs_r.byp[k];
			end
			// parallel: each core its own lane
			if (mode_q == wspci_pkg::MODE_PARALLEL || k == 0) begin
				si[k] = wrapper_serial_in[k];
			// parent's own output feeds the first subcore
			end else if (nested && k == PARENT + 1) begin
				si[k] = fs_r.own_so[PARENT];
			end else begin
				si[k] = fs_r.fin_so[k-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// rising edge: shift, capture, transfer

	always_comb begin
		rs_nxt = rs_r;
		for (int k = 0; k < NCORE; k++) begin
			// every core sees the same control pins
			if (instr_reg_select) begin
				// all instruction registers selected together, each shifts its own bits
				if (capture_ctrl) begin
					rs_nxt.ir_sh[k] = wspci_pkg::IR_CAPTURE;
				end else if (shift_ctrl) begin
					rs_nxt.ir_sh[k] = {si[k], rs_r.ir_sh[k][IW-1:1]};
				end
			end else begin
				if (capture_ctrl) begin
					rs_nxt.byp[k] = 1'b0;
				end else if (shift_ctrl) begin
					// one bypass bit per wrapper on the path
					rs_nxt.byp[k] = si[k];
				end
				if (fs_r.ir[k] == wspci_pkg::INSTR_EXTEST) begin
					if (capture_ctrl) begin
						rs_nxt.bnd[k] = core_func_in[k*BLEN +: BLEN];
					end else if (shift_ctrl) begin
						rs_nxt.bnd[k] = {si[k], rs_r.bnd[k][BLEN-1:1]};
					end else if (transfer_ctrl) begin
						rs_nxt.bnd[k] = core_func_out[k*BLEN +: BLEN];
					end
				end
			end
		end
	end

	// select, shift, capture and transfer taken on the rising edge
	always_ff @(posedge wrapper_test_clock or negedge wrapper_reset_n) begin
		if (!wrapper_reset_n) begin
			rs_r <= '0;
		end else begin
			rs_r <= rs_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// falling edge: update and serial outputs

	always_comb begin
		fs_nxt = fs_r;
		for (int k = 0; k < NCORE; k++) begin
			fs_nxt.own_so[k] = tail[k];
			fs_nxt.fin_so[k] = tail[k];
			if (nested && k == PARENT) begin
				// fixed chaining passes the returned bit straight through
				if (mode_q == wspci_pkg::MODE_NEST_FIXED) begin
					fs_nxt.fin_so[k] = ret;
				// multiplexed: subcores only while the parent links them in
				end else if (fs_r.ir[k] == wspci_pkg::INSTR_SUBLINK) begin
					fs_nxt.fin_so[k] = ret;
				end
			end
			if (update_ctrl && instr_reg_select) begin
				fs_nxt.ir[k] = rs_r.ir_sh[k];
				fs_nxt.byp_eff[k] = (rs_r.ir_sh[k] == wspci_pkg::INSTR_BYPASS);
			end
			if (update_ctrl && !instr_reg_select && fs_r.ir[k] == wspci_pkg::INSTR_EXTEST) begin
				fs_nxt.apl[k] = rs_r.bnd[k];
				fs_nxt.tgl[k] = !fs_r.tgl[k];
			end
		end
	end

	// the falling stage resets asynchronously, as the rising and auxiliary stages do, so a low wrapper reset never waits for a clock edge
	// low wrapper reset forces bypass at once
	// update taken on the falling edge
	always_ff @(negedge wrapper_test_clock or negedge wrapper_reset_n) begin
		if (!wrapper_reset_n) begin
			fs_r.ir <= '0;
			fs_r.byp_eff <= '1;
			fs_r.own_so <= '0;
			fs_r.fin_so <= '0;
			fs_r.apl <= '0;
			fs_r.tgl <= '0;
		end else begin
			fs_r <= fs_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// auxiliary clock: boundary apply stage

	// the toggle only says that new values wait; the values cross as a word that is
	// quasi-static by then, so no answer has to go back to the link side
	always_comb begin
		ax_nxt = ax_r;
		for (int k = 0; k < NCORE; k++) begin
			// the falling-edge stage is stable here once its toggle is seen
			if (tgl_q[k] != ax_r.seen[k]) begin
				ax_nxt.seen[k] = tgl_q[k];
				ax_nxt.apl[k] = fs_r.apl[k];
			end
		end
	end

	always_ff @(posedge auxiliary_clock or negedge wrapper_reset_n) begin
		if (!wrapper_reset_n) begin
			ax_r <= '0;
		end else begin
			ax_r <= ax_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign wrapper_serial_out = fs_r.fin_so;

	// the apply stage is taken from the auxiliary clock only when built that way
	// the choice is fixed at build time so each output stays a bare flop with no mux behind it
	generate
		if (USE_AUX) begin : g_aux_out
			assign core_func_out = ax_r.apl;
		end else begin : g_wrapper_test_clock_out
			assign core_func_out = fs_r.apl;
		end
	endgenerate

endmodule
